// file: logic/aoms_sequencer.v
// Operating-mode sequencer of the converter core
//
// Summary of operation
// RQ1: Mode zero after reset converts without pause, storing each result.
// RQ2: Each finished conversion drives the data/ready pin and ready flag low.
// RQ3: Host sets the continuous read bit to get continuous readout.
// RQ4: Continuous readout shifts each result out on serial clocks, no command.
// RQ5: Otherwise a read command makes the device output the conversion.
// RQ6: First result after reset or reconfiguration waits full settling time.
// RQ7: Single mode powers up, waits 200 us, then converts once.
// RQ8: Single conversion end stores result, asserts ready, powers down.
// RQ9: Result stays in data register until a later conversion replaces it.
// RQ10: Single mode keeps ready low until read or new conversion.
// RQ11: Idle holds filter and modulator in reset, modulator clocks running.
// RQ12: Power-down stops everything except a selected crystal oscillator.
// RQ13: Internal zero-scale shorts input, stores offset of selected channel.
// RQ14: Internal full-scale applies reference, stores full-scale coefficient.
// RQ15: Calibration drives ready high at start, low at completion.
// RQ16: After any calibration the device enters idle by itself.
// RQ17: Host sets clock halving below 4.75 V before internal full-scale.
// RQ18: System zero-scale measures selected channel, stores its offset.
// RQ19: System full-scale measures selected channel, stores its full-scale.
// RQ20: Host should recalibrate full-scale after a gain change.
// RQ21: Clock halving runs conversion logic at master clock over two.
// RQ22: A mode write aborts the operation and starts the new mode.
`timescale 1ns/1ps
`include "aoms_defs.vh"
module aoms_sequencer #(
    parameter [`AOMS_CNT_W-1:0] PWRUP_CYCLES = `AOMS_PWRUP_CYC
) (
    input  wire                    CORE_CLK,
    input  wire                    RESET_N,
    input  wire [2:0]              OPERATING_MODE_FIELD,
    input  wire                    MODE_WRITE,
    input  wire                    CONFIG_WRITE,
    input  wire                    CLK_HALVE,
    input  wire                    CONTINUOUS_READ_BIT,
    input  wire                    READ_CMD,
    input  wire [7:0]              CHANNEL_SELECT_BITS,
    input  wire [`AOMS_CNT_W-1:0]  SETTLE_TICKS,
    input  wire [`AOMS_CNT_W-1:0]  RATE_TICKS,
    input  wire [`AOMS_DATA_W-1:0] MOD_RESULT,
    input  wire                    XTAL_SELECTED,
    input  wire                    SCLK,
    input  wire                    CS_N,
    output wire                    DOUT_RDY_O,
    output wire                    DOUT_RDY_OE,
    output wire                    RDY_FLAG,
    output wire [2:0]              MODE_STATUS,
    output wire [`AOMS_DATA_W-1:0] DATA_REG,
    output wire                    OFFSET_WR,
    output wire                    FULLSCALE_WR,
    output wire [2:0]              COEF_CHANNEL,
    output wire [`AOMS_DATA_W-1:0] COEF_DATA,
    output wire                    FILTER_RESET,
    output wire                    MOD_CLK_EN,
    output wire                    POWER_DOWN,
    output wire                    XTAL_KEEP,
    output wire                    INPUT_SHORT,
    output wire                    INPUT_FULLSCALE
);

    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_SETTLE = 3'h1;
    localparam [2:0] ST_RUN    = 3'h2;
    localparam [2:0] ST_PWRUP  = 3'h3;
    localparam [2:0] ST_SINGLE = 3'h4;
    localparam [2:0] ST_PDN    = 3'h5;
    localparam [2:0] ST_CAL    = 3'h6;

    reg  [2:0]              state_ff;
    reg  [2:0]              nxt_state;
    reg  [2:0]              mode_ff;
    reg  [2:0]              nxt_mode;
    reg  [`AOMS_CNT_W-1:0]  cnt_ff;
    reg  [`AOMS_CNT_W-1:0]  nxt_cnt;
    reg  [`AOMS_DATA_W-1:0] data_ff;
    reg  [`AOMS_DATA_W-1:0] coef_ff;
    reg  [2:0]              coef_ch_ff;
    reg                     rdy_n_ff;
    reg                     off_wr_ff;
    reg                     fs_wr_ff;
    reg                     conv_done;
    reg                     cal_done;
    reg                     restart;
    wire                    tick;
    wire                    entering;
    wire                    conv_start;
    wire                    cal_start;
    wire                    sh_load;
    wire                    sh_bit;
    wire                    sh_busy;
    wire                    sh_done;
    wire                    cs_active;
    wire                    is_zero_cal;

    // Initial state of each mode
    function [2:0] entry_state;
        input [2:0] mode;
        begin
            case (mode)
                `AOMS_MODE_CONT:   entry_state = ST_SETTLE;
                `AOMS_MODE_SINGLE: entry_state = ST_PWRUP;
                `AOMS_MODE_IDLE:   entry_state = ST_IDLE;
                `AOMS_MODE_PDOWN:  entry_state = ST_PDN;
                default:           entry_state = ST_CAL;
            endcase
        end
    endfunction

    // Zero limit treated as one so a count always ends
    function cnt_hit;
        input [`AOMS_CNT_W-1:0] cnt;
        input [`AOMS_CNT_W-1:0] lim;
        begin
            cnt_hit = ({1'b0, cnt} + 17'h00001) >= {1'b0, lim};
        end
    endfunction

    // Lowest selected channel gets the coefficient
    function [2:0] chan_index;
        input [7:0] sel;
        integer i;
        begin
            chan_index = 3'h0;
            for (i = 7; i >= 0; i = i - 1) begin
                if (sel[i]) begin
                    chan_index = i[2:0];
                end
            end
        end
    endfunction

    aoms_clkdiv u_clkdiv (
        .clk   (CORE_CLK),
        .rst_n (RESET_N),
        .halve (CLK_HALVE),
        .tick  (tick)
    );

    always @* begin
        nxt_state = state_ff;
        nxt_mode  = mode_ff;
        nxt_cnt   = cnt_ff;
        conv_done = 1'b0;
        cal_done  = 1'b0;
        restart   = 1'b0;
        if (MODE_WRITE) begin
            // New mode always starts from scratch
            nxt_mode  = OPERATING_MODE_FIELD; // RQ22
            nxt_state = entry_state(OPERATING_MODE_FIELD); // RQ22
            nxt_cnt   = {`AOMS_CNT_W{1'b0}};
            restart   = 1'b1;
        end else if (CONFIG_WRITE) begin
            // Reconfiguration restarts the running mode
            nxt_state = entry_state(mode_ff); // RQ6
            nxt_cnt   = {`AOMS_CNT_W{1'b0}};
            restart   = 1'b1;
        end else begin
            case (state_ff)
                ST_SETTLE: begin
                    if (tick) begin
                        if (cnt_hit(cnt_ff, SETTLE_TICKS)) begin
                            conv_done = 1'b1; // RQ6
                            nxt_state = ST_RUN;
                            nxt_cnt   = {`AOMS_CNT_W{1'b0}};
                        end else begin
                            nxt_cnt = cnt_ff + 16'h0001;
                        end
                    end
                end
                ST_RUN: begin
                    if (tick) begin
                        if (cnt_hit(cnt_ff, RATE_TICKS)) begin
                            conv_done = 1'b1; // RQ1
                            nxt_cnt   = {`AOMS_CNT_W{1'b0}};
                        end else begin
                            nxt_cnt = cnt_ff + 16'h0001;
                        end
                    end
                end
                ST_PWRUP: begin
                    // Clock settle time counts raw cycles, not ticks
                    if (cnt_hit(cnt_ff, PWRUP_CYCLES)) begin
                        nxt_state = ST_SINGLE; // RQ7
                        nxt_cnt   = {`AOMS_CNT_W{1'b0}};
                    end else begin
                        nxt_cnt = cnt_ff + 16'h0001;
                    end
                end
                ST_SINGLE: begin
                    if (tick) begin
                        if (cnt_hit(cnt_ff, SETTLE_TICKS)) begin
                            conv_done = 1'b1; // RQ7
                            nxt_state = ST_PDN; // RQ8
                            nxt_cnt   = {`AOMS_CNT_W{1'b0}};
                        end else begin
                            nxt_cnt = cnt_ff + 16'h0001;
                        end
                    end
                end
                ST_CAL: begin
                    if (tick) begin
                        if (cnt_hit(cnt_ff, SETTLE_TICKS)) begin
                            cal_done  = 1'b1; // RQ15
                            nxt_state = ST_IDLE; // RQ16
                            nxt_mode  = `AOMS_MODE_IDLE; // RQ16
                            nxt_cnt   = {`AOMS_CNT_W{1'b0}};
                        end else begin
                            nxt_cnt = cnt_ff + 16'h0001;
                        end
                    end
                end
                ST_IDLE: begin
                    nxt_cnt = {`AOMS_CNT_W{1'b0}};
                end
                ST_PDN: begin
                    nxt_cnt = {`AOMS_CNT_W{1'b0}};
                end
                default: begin
                    nxt_state = ST_IDLE;
                    nxt_cnt   = {`AOMS_CNT_W{1'b0}};
                end
            endcase
        end
    end

    assign entering   = restart | (nxt_state != state_ff);
    assign conv_start = entering & (nxt_state == ST_SINGLE);
    assign cal_start  = entering & (nxt_state == ST_CAL);
    assign is_zero_cal = (mode_ff == `AOMS_MODE_ZS_INT) | (mode_ff == `AOMS_MODE_ZS_SYS);

    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            state_ff   <= ST_SETTLE;
            mode_ff    <= `AOMS_MODE_RESET;
            cnt_ff     <= {`AOMS_CNT_W{1'b0}};
            data_ff    <= {`AOMS_DATA_W{1'b0}};
            coef_ff    <= {`AOMS_DATA_W{1'b0}};
            coef_ch_ff <= 3'h0;
            rdy_n_ff   <= 1'b1;
            off_wr_ff  <= 1'b0;
            fs_wr_ff   <= 1'b0;
        end else begin
            state_ff  <= nxt_state;
            mode_ff   <= nxt_mode;
            cnt_ff    <= nxt_cnt;
            off_wr_ff <= 1'b0;
            fs_wr_ff  <= 1'b0;
            // Held until the next conversion overwrites it
            if (conv_done) begin
                data_ff <= MOD_RESULT; // RQ9
            end
            // Completion beats a same-cycle read so no result is hidden
            if (conv_done || cal_done) begin
                rdy_n_ff <= 1'b0; // RQ2
            end else if (cal_start || conv_start || sh_done) begin
                rdy_n_ff <= 1'b1; // RQ10
            end
            if (cal_done) begin
                coef_ff    <= MOD_RESULT;
                coef_ch_ff <= chan_index(CHANNEL_SELECT_BITS); // RQ18 RQ19
                off_wr_ff  <= is_zero_cal; // RQ13
                fs_wr_ff   <= ~is_zero_cal; // RQ14
            end
        end
    end

    // Each fresh result loads once in continuous read
    assign sh_load = cs_active & ~sh_busy & ~sh_done &
                     ((CONTINUOUS_READ_BIT & ~rdy_n_ff) | READ_CMD); // RQ4

    aoms_shifter u_shifter (
        .clk       (CORE_CLK),
        .rst_n     (RESET_N),
        .sclk_pin  (SCLK),
        .cs_n_pin  (CS_N),
        .load      (sh_load),
        .load_data (data_ff),
        .dout_bit  (sh_bit),
        .busy      (sh_busy),
        .done      (sh_done),
        .cs_active (cs_active)
    );

    // Pin shows ready when no word is moving
    assign DOUT_RDY_O   = sh_busy ? sh_bit : rdy_n_ff; // RQ5
    assign DOUT_RDY_OE  = cs_active;
    assign RDY_FLAG     = rdy_n_ff; // RQ2
    assign MODE_STATUS  = mode_ff;
    assign DATA_REG     = data_ff;
    assign OFFSET_WR    = off_wr_ff;
    assign FULLSCALE_WR = fs_wr_ff;
    assign COEF_CHANNEL = coef_ch_ff;
    assign COEF_DATA    = coef_ff;

    // Idle keeps clocks but holds the filter
    assign FILTER_RESET = (state_ff == ST_IDLE) | (state_ff == ST_PDN) |
                          (state_ff == ST_PWRUP); // RQ11
    assign MOD_CLK_EN   = (state_ff != ST_PDN) & (state_ff != ST_PWRUP); // RQ11
    assign POWER_DOWN   = (state_ff == ST_PDN); // RQ12
    // Crystal stays up so wake-up skips its start-up time
    assign XTAL_KEEP    = XTAL_SELECTED; // RQ12
    assign INPUT_SHORT  = (state_ff == ST_CAL) & (mode_ff == `AOMS_MODE_ZS_INT); // RQ13
    assign INPUT_FULLSCALE = (state_ff == ST_CAL) & (mode_ff == `AOMS_MODE_FS_INT); // RQ14

endmodule // aoms_sequencer

// file: common/aoms_defs.vh
// Constants of the operating-mode sequencer
`ifndef AOMS_DEFS_VH
`define AOMS_DEFS_VH

`define AOMS_MODE_CONT      3'h0
`define AOMS_MODE_SINGLE    3'h1
`define AOMS_MODE_IDLE      3'h2
`define AOMS_MODE_PDOWN     3'h3
`define AOMS_MODE_ZS_INT    3'h4
`define AOMS_MODE_FS_INT    3'h5
`define AOMS_MODE_ZS_SYS    3'h6
`define AOMS_MODE_FS_SYS    3'h7
`define AOMS_MODE_RESET     3'h0

`define AOMS_DATA_W         24
`define AOMS_CNT_W          16
`define AOMS_BITCNT_W       5
`define AOMS_LAST_BIT       5'h17

`define AOMS_PWRUP_CYC      16'h61a8

`endif

// file: logic/aoms_clkdiv.v
// Conversion tick divider, full rate or master clock halved
`timescale 1ns/1ps
module aoms_clkdiv (
    input  wire clk,
    input  wire rst_n,
    input  wire halve,
    output wire tick
);

    reg         phase_ff;
    reg         tick_ff;
    wire        nxt_phase;
    wire        nxt_tick;

    assign nxt_phase = halve ? ~phase_ff : 1'b0;
    assign nxt_tick  = halve ? phase_ff : 1'b1; // RQ21

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_ff <= 1'b0;
            tick_ff  <= 1'b0;
        end else begin
            phase_ff <= nxt_phase;
            tick_ff  <= nxt_tick;
        end
    end

    assign tick = tick_ff;

endmodule // aoms_clkdiv

// file: logic/aoms_shifter.v
// Serial output shifter with synchronised serial clock and select
`timescale 1ns/1ps
`include "aoms_defs.vh"
module aoms_shifter (
    input  wire                    clk,
    input  wire                    rst_n,
    input  wire                    sclk_pin,
    input  wire                    cs_n_pin,
    input  wire                    load,
    input  wire [`AOMS_DATA_W-1:0] load_data,
    output wire                    dout_bit,
    output wire                    busy,
    output wire                    done,
    output wire                    cs_active
);

    reg                       sclk_s1_ff;
    reg                       sclk_s2_ff;
    reg                       sclk_s3_ff;
    reg                       cs_s1_ff;
    reg                       cs_s2_ff;
    reg [`AOMS_DATA_W-1:0]    sh_ff;
    reg [`AOMS_BITCNT_W-1:0]  bit_ff;
    reg                       busy_ff;
    reg                       done_ff;
    wire                      sclk_rise;
    wire                      sclk_fall;

    assign sclk_rise = sclk_s2_ff & ~sclk_s3_ff;
    assign sclk_fall = ~sclk_s2_ff & sclk_s3_ff;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_s1_ff <= 1'b1;
            sclk_s2_ff <= 1'b1;
            sclk_s3_ff <= 1'b1;
            cs_s1_ff   <= 1'b1;
            cs_s2_ff   <= 1'b1;
            sh_ff      <= {`AOMS_DATA_W{1'b0}};
            bit_ff     <= {`AOMS_BITCNT_W{1'b0}};
            busy_ff    <= 1'b0;
            done_ff    <= 1'b0;
        end else begin
            sclk_s1_ff <= sclk_pin;
            sclk_s2_ff <= sclk_s1_ff;
            sclk_s3_ff <= sclk_s2_ff;
            cs_s1_ff   <= cs_n_pin;
            cs_s2_ff   <= cs_s1_ff;
            done_ff    <= 1'b0;
            if (cs_s2_ff) begin
                // Deselect abandons a read half way
                busy_ff <= 1'b0;
            end else if (load && !busy_ff) begin
                sh_ff   <= load_data;
                bit_ff  <= {`AOMS_BITCNT_W{1'b0}};
                busy_ff <= 1'b1;
            end else if (busy_ff) begin
                if (sclk_fall && bit_ff != {`AOMS_BITCNT_W{1'b0}}) begin
                    sh_ff <= {sh_ff[`AOMS_DATA_W-2:0], 1'b0};
                end
                if (sclk_rise) begin
                    bit_ff <= bit_ff + 5'h01;
                    if (bit_ff == `AOMS_LAST_BIT) begin
                        busy_ff <= 1'b0;
                        done_ff <= 1'b1;
                    end
                end
            end
        end
    end

    assign dout_bit  = sh_ff[`AOMS_DATA_W-1];
    assign busy      = busy_ff;
    assign done      = done_ff;
    assign cs_active = ~cs_s2_ff;

endmodule // aoms_shifter

// file: bench/aoms_host_model.sv
// Host model: drives the serial clock, select and read command
`timescale 1ns/1ps
module aoms_host_model (
    input  wire clk,
    input  wire dout,
    input  wire dout_oe,
    output reg  sclk,
    output reg  cs_n,
    output reg  read_cmd
);
    initial begin
        {sclk, cs_n, read_cmd} = 3'h6;
    end
    task read_word(input use_cmd, output [23:0] word, output ok);
        integer i, n;
        begin
            ok = 1'b1;
            word = 24'h0;
            @(negedge clk) cs_n = 1'b0;
            repeat (4) @(negedge clk);
            if (use_cmd) begin
                read_cmd = 1'b1;
                @(negedge clk) read_cmd = 1'b0;
            end else begin
                n = 0;
                // Ready shows as a low pin while selected
                while ((dout_oe !== 1'b1 || dout !== 1'b0) && n < 1200) begin
                    @(negedge clk);
                    n = n + 1;
                end
                ok = (n < 1200);
            end
            repeat (3) @(negedge clk);
            // Above the 3-cycle sync need
            for (i = 23; i >= 0; i = i - 1) begin
                sclk = 1'b0;
                repeat (4) @(negedge clk);
                sclk = 1'b1;
                word[i] = dout;
                repeat (4) @(negedge clk);
            end
            repeat (2) @(negedge clk);
            cs_n = 1'b1;
            @(negedge clk);
        end
    endtask
endmodule // aoms_host_model

// file: bench/aoms_sequencer_sva.sv
// Checker on the sequencer ports
`timescale 1ns/1ps
`include "aoms_defs.vh"
module aoms_sequencer_chk #(
    parameter [15:0] PWRUP_CYCLES = 16'h0014
) (
    input wire        CORE_CLK,
    input wire        RESET_N,
    input wire [2:0]  OPERATING_MODE_FIELD,
    input wire        MODE_WRITE,
    input wire        CS_N,
    input wire        XTAL_SELECTED,
    input wire        DOUT_RDY_OE,
    input wire        RDY_FLAG,
    input wire [2:0]  MODE_STATUS,
    input wire [23:0] DATA_REG,
    input wire        OFFSET_WR,
    input wire        FULLSCALE_WR,
    input wire        FILTER_RESET,
    input wire        MOD_CLK_EN,
    input wire        POWER_DOWN,
    input wire        XTAL_KEEP,
    input wire        INPUT_SHORT
);
    reg [16:0] pw_cnt_ff;
    wire [16:0] nxt_pw_cnt = (!MOD_CLK_EN && !POWER_DOWN) ? pw_cnt_ff + 17'h1 : 17'h0;
    always @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) pw_cnt_ff <= 17'h0;
        else pw_cnt_ff <= nxt_pw_cnt;
    end
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RESET_N);
    mode_take_a: assert property (MODE_WRITE |=> MODE_STATUS == $past(OPERATING_MODE_FIELD))
        else $error("mode not taken");
    cal_start_a: assert property (MODE_WRITE && OPERATING_MODE_FIELD[2] |=> RDY_FLAG && !OFFSET_WR)
        else $error("no ready at cal start");
    offset_end_a: assert property (OFFSET_WR |-> MODE_STATUS == `AOMS_MODE_IDLE && !RDY_FLAG)
        else $error("bad offset write");
    fscale_end_a: assert property (FULLSCALE_WR |-> !RDY_FLAG && !OFFSET_WR ##1 !FULLSCALE_WR)
        else $error("bad full-scale write");
    idle_state_a: assert property (MODE_STATUS == `AOMS_MODE_IDLE |-> FILTER_RESET && MOD_CLK_EN)
        else $error("bad idle outputs");
    pdown_state_a: assert property (MODE_STATUS == `AOMS_MODE_PDOWN && $stable(XTAL_SELECTED)
        |-> POWER_DOWN && !MOD_CLK_EN && XTAL_KEEP == XTAL_SELECTED) else $error("bad power-down");
    data_new_a: assert property ($changed(DATA_REG) |-> !RDY_FLAG)
        else $error("data without ready");
    short_only_a: assert property (INPUT_SHORT |-> MODE_STATUS == `AOMS_MODE_ZS_INT)
        else $error("stray input short");
    oe_follow_a: assert property ($stable(CS_N)[*3] |-> DOUT_RDY_OE == !CS_N)
        else $error("enable not following select");
    single_start_a: assert property (MODE_WRITE && OPERATING_MODE_FIELD == `AOMS_MODE_SINGLE
        |=> !MOD_CLK_EN && FILTER_RESET && !POWER_DOWN) else $error("no single power-up");
    pwrup_wait_a: assert property (pw_cnt_ff <= {1'b0, PWRUP_CYCLES} + 17'h1)
        else $error("power-up too long");
    cover property (OFFSET_WR);
    cover property (FULLSCALE_WR);
    cover property ($rose(POWER_DOWN));
    cover property ($fell(RDY_FLAG) && DOUT_RDY_OE);
endmodule // aoms_sequencer_chk
bind aoms_sequencer aoms_sequencer_chk #(.PWRUP_CYCLES(PWRUP_CYCLES)) chk_u (
    .CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .OPERATING_MODE_FIELD(OPERATING_MODE_FIELD),
    .MODE_WRITE(MODE_WRITE), .CS_N(CS_N), .XTAL_SELECTED(XTAL_SELECTED), .DOUT_RDY_OE(DOUT_RDY_OE),
    .RDY_FLAG(RDY_FLAG), .MODE_STATUS(MODE_STATUS), .DATA_REG(DATA_REG), .OFFSET_WR(OFFSET_WR),
    .FULLSCALE_WR(FULLSCALE_WR), .FILTER_RESET(FILTER_RESET), .MOD_CLK_EN(MOD_CLK_EN),
    .POWER_DOWN(POWER_DOWN), .XTAL_KEEP(XTAL_KEEP), .INPUT_SHORT(INPUT_SHORT));

// file: bench/aoms_sequencer_test.sv
// Testbench of the mode sequencer
`timescale 1ns/1ps
`include "aoms_defs.vh"
module aoms_sequencer_test;
    localparam integer PW = 20;
    localparam integer ST = 16;
    reg        CORE_CLK, RESET_N, MODE_WRITE, CONFIG_WRITE, CLK_HALVE, CONTINUOUS_READ_BIT, XTAL_SELECTED;
    reg [2:0]  OPERATING_MODE_FIELD;
    reg [7:0]  CHANNEL_SELECT_BITS;
    reg [23:0] MOD_RESULT;
    wire       SCLK, CS_N, READ_CMD, DOUT_RDY_O, DOUT_RDY_OE, RDY_FLAG, OFFSET_WR, FULLSCALE_WR;
    wire       FILTER_RESET, MOD_CLK_EN, POWER_DOWN, XTAL_KEEP, INPUT_SHORT, INPUT_FULLSCALE;
    wire [2:0] MODE_STATUS, COEF_CHANNEL;
    wire [23:0] DATA_REG, COEF_DATA;
    integer    err_count, n_compared, n, k;
    reg [23:0] w;
    reg        ok, coef_seen;
    aoms_sequencer #(.PWRUP_CYCLES(16'h0014)) dut_u (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N),
        .OPERATING_MODE_FIELD(OPERATING_MODE_FIELD), .MODE_WRITE(MODE_WRITE), .CONFIG_WRITE(CONFIG_WRITE),
        .CLK_HALVE(CLK_HALVE), .CONTINUOUS_READ_BIT(CONTINUOUS_READ_BIT), .READ_CMD(READ_CMD),
        .CHANNEL_SELECT_BITS(CHANNEL_SELECT_BITS), .SETTLE_TICKS(16'h0010), .RATE_TICKS(16'h0200),
        .MOD_RESULT(MOD_RESULT), .XTAL_SELECTED(XTAL_SELECTED), .SCLK(SCLK), .CS_N(CS_N),
        .DOUT_RDY_O(DOUT_RDY_O), .DOUT_RDY_OE(DOUT_RDY_OE), .RDY_FLAG(RDY_FLAG), .MODE_STATUS(MODE_STATUS),
        .DATA_REG(DATA_REG), .OFFSET_WR(OFFSET_WR), .FULLSCALE_WR(FULLSCALE_WR), .COEF_CHANNEL(COEF_CHANNEL),
        .COEF_DATA(COEF_DATA), .FILTER_RESET(FILTER_RESET), .MOD_CLK_EN(MOD_CLK_EN), .POWER_DOWN(POWER_DOWN),
        .XTAL_KEEP(XTAL_KEEP), .INPUT_SHORT(INPUT_SHORT), .INPUT_FULLSCALE(INPUT_FULLSCALE));
    aoms_host_model host_u (.clk(CORE_CLK), .dout(DOUT_RDY_O), .dout_oe(DOUT_RDY_OE), .sclk(SCLK),
        .cs_n(CS_N), .read_cmd(READ_CMD));
    initial begin
        CORE_CLK = 1'b0;
        forever #4 CORE_CLK = ~CORE_CLK;
    end
    always @(posedge CORE_CLK) if (OFFSET_WR || FULLSCALE_WR) coef_seen <= 1'b1;
    task chk(input [23:0] got, input [23:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task chk_rng(input integer got, input integer lo, input integer hi);
        begin
            n_compared = n_compared + 1;
            if (got < lo || got > hi) begin
                err_count = err_count + 1;
                $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
            end
        end
    endtask
    task mode(input [2:0] m);
        begin
            @(negedge CORE_CLK) OPERATING_MODE_FIELD = m;
            MODE_WRITE = 1'b1;
            @(negedge CORE_CLK) MODE_WRITE = 1'b0;
        end
    endtask
    // Bounded, so a hang still ends
    task wait_data(input [23:0] exp);
        begin
            n = 0;
            while (DATA_REG !== exp && n < 2000) begin
                @(negedge CORE_CLK);
                n = n + 1;
            end
        end
    endtask
    task t_cont;
        begin
            wait_data(24'ha5c3e1);
            chk_rng(n, ST - 1, ST + 3);
            chk({23'h0, RDY_FLAG}, 24'h0);
            host_u.read_word(1'b1, w, ok);
            chk(w, 24'ha5c3e1);
            chk({23'h0, RDY_FLAG}, 24'h1);
        end
    endtask
    task t_continuous_read_bit;
        begin
            CONTINUOUS_READ_BIT = 1'b1;
            MOD_RESULT = 24'hc3a55a;
            host_u.read_word(1'b0, w, ok);
            chk({23'h0, ok}, 24'h1);
            chk(w, 24'hc3a55a);
            CONTINUOUS_READ_BIT = 1'b0;
        end
    endtask
    task t_abort;
        begin
            mode(`AOMS_MODE_ZS_INT);
            repeat (5) @(negedge CORE_CLK);
            coef_seen = 1'b0;
            mode(`AOMS_MODE_CONT);
            repeat (5) @(negedge CORE_CLK);
            MOD_RESULT = 24'h5a0f33;
            CONFIG_WRITE = 1'b1;
            @(negedge CORE_CLK) CONFIG_WRITE = 1'b0;
            wait_data(24'h5a0f33);
            chk_rng(n, ST - 2, ST + 2);
            chk({23'h0, coef_seen}, 24'h0);
            chk({21'h0, MODE_STATUS}, 24'h0);
        end
    endtask
    task t_single;
        begin
            MOD_RESULT = 24'h81f00d;
            mode(`AOMS_MODE_SINGLE);
            chk({21'h0, MOD_CLK_EN, FILTER_RESET, POWER_DOWN}, 24'h2);
            wait_data(24'h81f00d);
            chk_rng(n, PW + ST - 1, PW + ST + 4);
            chk({22'h0, RDY_FLAG, POWER_DOWN}, 24'h1);
            MOD_RESULT = 24'h0a0b0c;
            repeat (60) @(negedge CORE_CLK);
            chk(DATA_REG, 24'h81f00d);
            chk({23'h0, RDY_FLAG}, 24'h0);
            host_u.read_word(1'b1, w, ok);
            chk(w, 24'h81f00d);
            chk({23'h0, RDY_FLAG}, 24'h1);
        end
    endtask
    task t_cal;
        begin
            CHANNEL_SELECT_BITS = 8'h28;
            for (k = 4; k < 8; k = k + 1) begin
                MOD_RESULT = 24'h700000 + k;
                CLK_HALVE = (k == 5);
                mode(k[2:0]);
                chk({21'h0, RDY_FLAG, INPUT_SHORT, INPUT_FULLSCALE}, {21'h0, 1'b1, k == 4, k == 5});
                n = 0;
                while (!(OFFSET_WR || FULLSCALE_WR) && n < 100) begin
                    @(negedge CORE_CLK);
                    n = n + 1;
                end
                chk({22'h0, OFFSET_WR, FULLSCALE_WR}, {22'h0, !k[0], k[0]});
                chk({21'h0, COEF_CHANNEL}, 24'h3);
                chk(COEF_DATA, 24'h700000 + k);
                chk({20'h0, MODE_STATUS, RDY_FLAG}, 24'h4);
                chk({22'h0, FILTER_RESET, MOD_CLK_EN}, 24'h3);
            end
            CLK_HALVE = 1'b0;
        end
    endtask
    task t_pdown;
        begin
            XTAL_SELECTED = 1'b1;
            mode(`AOMS_MODE_PDOWN);
            chk({21'h0, POWER_DOWN, MOD_CLK_EN, XTAL_KEEP}, 24'h5);
            XTAL_SELECTED = 1'b0;
            @(negedge CORE_CLK);
            chk({23'h0, XTAL_KEEP}, 24'h0);
        end
    endtask
    task t_halve;
        begin
            CLK_HALVE = 1'b1;
            MOD_RESULT = 24'h6d2e71;
            mode(`AOMS_MODE_CONT);
            wait_data(24'h6d2e71);
            chk_rng(n, 2 * ST - 2, 2 * ST + 4);
            CLK_HALVE = 1'b0;
        end
    endtask
    task wrap_up;
        begin
            $display("errors=%0d compared=%0d", err_count, n_compared);
            if (err_count == 0 && n_compared > 0) $display("Testbench passed");
            else $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        {MODE_WRITE, CONFIG_WRITE, CLK_HALVE, CONTINUOUS_READ_BIT, XTAL_SELECTED, coef_seen} = 6'h0;
        OPERATING_MODE_FIELD = 3'h0;
        CHANNEL_SELECT_BITS = 8'h01;
        MOD_RESULT = 24'ha5c3e1;
        err_count = 0;
        n_compared = 0;
        RESET_N = 1'b0;
        repeat (4) @(posedge CORE_CLK);
        @(negedge CORE_CLK) RESET_N = 1'b1;
        t_cont;
        t_continuous_read_bit;
        t_abort;
        t_single;
        t_cal;
        t_pdown;
        t_halve;
        wrap_up;
    end
    // Run needs about 1200 cycles
    initial begin
        #200000;
        err_count = err_count + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, 24'h0, 24'h1);
        wrap_up;
    end
endmodule // aoms_sequencer_test
